// ### shared/hsap_regs.svh
// Register offsets, field positions, reset values and pointer limits
// Assumes inclusion by bare name from the top module
`ifndef HSAP_REGS_SVH
`define HSAP_REGS_SVH
`define HSAP_PAD_CTRL     8'h38
`define HSAP_IRQ_CTRL     8'h39
`define HSAP_CLK_STOP     8'h50
`define HSAP_CLK_RESUME   8'h51
`define HSAP_RX_PREFETCH  8'hF0
`define HSAP_RX_PEEK      8'hF1
`define HSAP_RX_STREAM    8'hF2
`define HSAP_RX_PTR_HI    8'hF4
`define HSAP_RX_PTR_LO    8'hF5
`define HSAP_TX_FIXED     8'hF6
`define HSAP_TX_STREAM    8'hF8
`define HSAP_TX_PTR_HI    8'hFA
`define HSAP_TX_PTR_LO    8'hFB
`define HSAP_TX_LEN_HI    8'hFC
`define HSAP_TX_LEN_LO    8'hFD
`define HSAP_EVENTS       8'hFE
`define HSAP_IRQ_ENABLE   8'hFF
`define HSAP_PAD_RESET    8'h01
`define HSAP_WRAP_BIT     7
`define HSAP_WIDTH_BIT    7
`define HSAP_RX_WRAP_HI   8'h0C
`define HSAP_RX_START     16'h0C00
`define HSAP_RX_END       16'h3FFF
`define HSAP_TX_START     16'h0000
`define HSAP_TX_END       16'h0BFF
`endif

// ### shared/hsap_pkg.sv
// Types shared by the host access port
// Assumes the register header sits beside it on the include path
`default_nettype none
package hsap_pkg;
  // One transmit SRAM write waiting in the buffer
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic        wide;
  } hsap_txw_t;
  // Synchronised host strobes and selects
  typedef struct packed {
    logic cs_n;
    logic cmd;
    logic ior_n;
    logic iow_n;
  } hsap_pins_t;
endpackage : hsap_pkg
`default_nettype wire

// ### design/hsap_top.sv
// Host index/data access port: registers, SRAM data ports, irq pin
// Assumes asynchronous host pins, a 1-cycle-latency RX SRAM read port
// and a TX SRAM write port on the same 20 MHz clock.
// How it works
// - Irq control bit 1 picks open-collector output
// - Irq control bit 0 picks active-low irq
// - Clock stop bit 0 stops clock, powers down PHY
// - Selecting resume index restarts the system clock
// - Prefetch read returns data, starts prefetching
// - Peek read returns data, pointer unchanged
// - Stream read advances pointer by 1 or 2
// - Read pointer high/low bytes are read/write
// - Setting wrap enable loads read high byte
// - Fixed write stores data, pointer unchanged
// - Stream write advances pointer by 1 or 2
// - Write pointer high/low bytes are read/write
// - Transmit length held as high/low bytes
// - Status bit 7 reports bus width mode
// - Six event flags clear on writing 1
// - Optional glitch filtering of both strobes
// - Two-bit drive strength field for pads
// - Wrap enable folds pointers past SRAM end
// - Enable bits 5..0 gate matching flags
`include "hsap_regs.svh"
`default_nettype none
module hsap_top
  import hsap_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_cs_n,
  input  wire logic        i_cmd,
  input  wire logic        i_ior_n,
  input  wire logic        i_iow_n,
  input  wire logic [15:0] i_data,
  output logic      [15:0] o_data,
  output logic             o_data_oe,
  output logic             o_io_wait,
  input  wire logic        i_bus_8bit,
  output logic             o_irq,
  output logic             o_irq_oe,
  input  wire logic [5:0]  i_event,
  output logic             o_sys_clk_stop,
  output logic             o_phy_power_down,
  output logic [1:0]       o_drive_strength,
  output logic             o_hysteresis_en,
  output logic [15:0]      o_rx_addr,
  input  wire logic [15:0] i_rx_data,
  output logic             o_rx_prefetch,
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  output hsap_txw_t        o_tx_word,
  output logic [15:0]      o_tx_length
);

  // ==========================================================
  // Pointer step with optional fold back to region start
  // ==========================================================
  function automatic logic [15:0] step_ptr(
    input logic [15:0] ptr,
    input logic        wide,
    input logic        wrap,
    input logic [15:0] first,
    input logic [15:0] last
  );
    logic [15:0] nxt;
    nxt = ptr + (wide ? 16'h0002 : 16'h0001);
    if (wrap && (ptr > last - (wide ? 16'h0002 : 16'h0001)))
      nxt = first + (nxt - last - 16'h0001);
    return nxt;
  endfunction : step_ptr

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  hsap_pins_t  pin_s1;
  hsap_pins_t  pin_s2;
  logic [15:0] dat_s1;
  logic [15:0] dat_s2;
  logic        width_s1;
  logic        width_s2;
  logic        ior_s3;
  logic        iow_s3;

  // Two flops on every asynchronous pin; stage one feeds stage two only
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_s1   <= '{cs_n: 1'b1, cmd: 1'b0, ior_n: 1'b1, iow_n: 1'b1};
      pin_s2   <= '{cs_n: 1'b1, cmd: 1'b0, ior_n: 1'b1, iow_n: 1'b1};
      dat_s1   <= 16'h0000;
      dat_s2   <= 16'h0000;
      ior_s3   <= 1'b1;
      iow_s3   <= 1'b1;
    end
    else
    begin
      pin_s1   <= '{cs_n: i_cs_n, cmd: i_cmd, ior_n: i_ior_n,
                    iow_n: i_iow_n};
      pin_s2   <= pin_s1;
      dat_s1   <= i_data;
      dat_s2   <= dat_s1;
      ior_s3   <= pin_s2.ior_n;
      iow_s3   <= pin_s2.iow_n;
    end
  end

  // Strap sync runs through reset, so the capture sees the settled pin
  always_ff @(posedge i_ref_clk)
  begin
    width_s1 <= i_bus_8bit;
    width_s2 <= width_s1;
  end

  // ==========================================================
  // Strobe glitch filters and edge detection
  // ==========================================================
  logic [7:0] pad_ctrl;
  logic       ior_f;
  logic       iow_f;
  logic       ior_d;
  logic       iow_d;
  logic       cs_l;
  logic       cmd_l;

  // A spike far below one period cannot survive two equal samples
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ior_f <= 1'b1;
      iow_f <= 1'b1;
      ior_d <= 1'b1;
      iow_d <= 1'b1;
    end
    else
    begin
      if (!pad_ctrl[0] || pin_s2.ior_n == ior_s3)
        ior_f <= pin_s2.ior_n;
      if (!pad_ctrl[1] || pin_s2.iow_n == iow_s3)
        iow_f <= pin_s2.iow_n;
      ior_d <= ior_f;
      iow_d <= iow_f;
    end
  end

  // Selects are latched while a strobe is low, since they may drop early
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cs_l  <= 1'b0;
      cmd_l <= 1'b0;
    end
    else if (!ior_f || !iow_f)
    begin
      cs_l  <= !pin_s2.cs_n;
      cmd_l <= pin_s2.cmd;
    end
  end

  logic read_end;
  logic write_end;
  logic data_wr;
  logic index_wr;
  assign read_end  = ior_f && !ior_d && cs_l && cmd_l;
  assign write_end = iow_f && !iow_d && cs_l;
  assign data_wr   = write_end && cmd_l;
  assign index_wr  = write_end && !cmd_l;

  // ==========================================================
  // Bus width strap, caught once after reset release
  // ==========================================================
  logic narrow;
  logic strap_done;
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      narrow     <= 1'b0;
      strap_done <= 1'b0;
    end
    else if (!strap_done)
    begin
      narrow     <= width_s2;
      strap_done <= 1'b1;
    end
  end
  logic wide;
  assign wide = !narrow;

  // ==========================================================
  // Index and configuration registers
  // ==========================================================
  logic [7:0] index;
  logic [1:0] irq_ctrl;
  logic [7:0] irq_enable;
  logic       clk_stop;
  logic [7:0] wbyte;
  assign wbyte = dat_s2[7:0];

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      index <= 8'h00;
    else if (index_wr)
      index <= wbyte;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pad_ctrl   <= `HSAP_PAD_RESET;
      irq_ctrl   <= 2'h0;
      irq_enable <= 8'h00;
    end
    else if (data_wr)
    begin
      if (index == `HSAP_PAD_CTRL)
        pad_ctrl <= wbyte;
      if (index == `HSAP_IRQ_CTRL)
        irq_ctrl <= wbyte[1:0];
      if (index == `HSAP_IRQ_ENABLE)
        irq_enable <= {wbyte[7], 1'b0, wbyte[5:0]};
    end
  end

  // Resume is the index value itself; no data cycle is needed
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      clk_stop <= 1'b0;
    else if (index_wr && wbyte == `HSAP_CLK_RESUME)
      clk_stop <= 1'b0;
    else if (data_wr && index == `HSAP_CLK_STOP)
      clk_stop <= wbyte[0];
  end

  assign o_sys_clk_stop   = clk_stop;
  assign o_phy_power_down = clk_stop;
  assign o_drive_strength = pad_ctrl[6:5];
  assign o_hysteresis_en  = pad_ctrl[3];

  // ==========================================================
  // Event flags
  // ==========================================================
  logic [5:0] flags;
  logic       flags_wr;
  assign flags_wr = data_wr && index == `HSAP_EVENTS;

  // A new event in the clearing cycle beats the clear
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_flag
      always_ff @(posedge i_ref_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
          flags[gi] <= 1'b0;
        else if (i_event[gi])
          flags[gi] <= 1'b1;
        else if (flags_wr && wbyte[gi])
          flags[gi] <= 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // Interrupt pin
  // ==========================================================
  logic irq_active;
  assign irq_active = |(flags & irq_enable[5:0]);

  // Open collector can only pull low, so it drives 0 when asserted
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_irq    <= 1'b0;
      o_irq_oe <= 1'b0;
    end
    else if (irq_ctrl[1])
    begin
      o_irq    <= 1'b0;
      o_irq_oe <= irq_active;
    end
    else
    begin
      o_irq    <= irq_ctrl[0] ? !irq_active : irq_active;
      o_irq_oe <= 1'b1;
    end
  end

  // ==========================================================
  // Receive pointer and prefetch buffer
  // ==========================================================
  logic [15:0] rx_ptr;
  logic [15:0] rx_buf;
  logic        rx_adv;
  assign rx_adv = read_end && index == `HSAP_RX_STREAM;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rx_ptr <= 16'h0000;
    else if (data_wr && index == `HSAP_IRQ_ENABLE
             && wbyte[`HSAP_WRAP_BIT])
      rx_ptr[15:8] <= `HSAP_RX_WRAP_HI;
    else if (data_wr && index == `HSAP_RX_PTR_HI)
      rx_ptr[15:8] <= wbyte;
    else if (data_wr && index == `HSAP_RX_PTR_LO)
      rx_ptr[7:0] <= wbyte;
    else if (rx_adv)
      rx_ptr <= step_ptr(rx_ptr, wide, irq_enable[`HSAP_WRAP_BIT],
                         `HSAP_RX_START, `HSAP_RX_END);
  end

  // SRAM word at the pointer is kept fresh for the next host read
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rx_buf        <= 16'h0000;
      o_rx_prefetch <= 1'b0;
    end
    else
    begin
      rx_buf        <= i_rx_data;
      o_rx_prefetch <= read_end && index == `HSAP_RX_PREFETCH;
    end
  end
  assign o_rx_addr = rx_ptr;

  // ==========================================================
  // Transmit pointer, length and two-entry write buffer
  // ==========================================================
  logic [15:0] tx_ptr;
  logic [15:0] tx_len;
  logic        tx_put;
  logic        tx_in_ready;
  assign tx_put = data_wr && (index == `HSAP_TX_FIXED
                              || index == `HSAP_TX_STREAM);

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      tx_ptr <= 16'h0000;
    else if (data_wr && index == `HSAP_TX_PTR_HI)
      tx_ptr[15:8] <= wbyte;
    else if (data_wr && index == `HSAP_TX_PTR_LO)
      tx_ptr[7:0] <= wbyte;
    else if (tx_put && tx_in_ready && index == `HSAP_TX_STREAM)
      tx_ptr <= step_ptr(tx_ptr, wide, irq_enable[`HSAP_WRAP_BIT],
                         `HSAP_TX_START, `HSAP_TX_END);
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      tx_len <= 16'h0000;
    else if (data_wr && index == `HSAP_TX_LEN_HI)
      tx_len[15:8] <= wbyte;
    else if (data_wr && index == `HSAP_TX_LEN_LO)
      tx_len[7:0] <= wbyte;
  end
  assign o_tx_length = tx_len;

  // Host cannot be stalled mid-cycle; it must honour the wait pin
  hsap_txw_t   tx_mem [2];
  logic        tx_wp;
  logic        tx_rp;
  logic [1:0]  tx_cnt;
  logic        tx_pop;
  assign tx_in_ready = tx_cnt != 2'h2;
  assign tx_pop      = o_tx_valid && i_tx_ready;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tx_wp     <= 1'b0;
      tx_rp     <= 1'b0;
      tx_cnt    <= 2'h0;
      tx_mem[0] <= '0;
      tx_mem[1] <= '0;
    end
    else
    begin
      if (tx_put && tx_in_ready)
      begin
        tx_mem[tx_wp] <= '{addr: tx_ptr, data: wide ? dat_s2
                           : {8'h00, wbyte}, wide: wide};
        tx_wp <= !tx_wp;
      end
      if (tx_pop)
        tx_rp <= !tx_rp;
      if ((tx_put && tx_in_ready) && !tx_pop)
        tx_cnt <= tx_cnt + 2'h1;
      else if (!(tx_put && tx_in_ready) && tx_pop)
        tx_cnt <= tx_cnt - 2'h1;
    end
  end
  assign o_tx_valid = tx_cnt != 2'h0;
  assign o_tx_word  = tx_mem[tx_rp];
  assign o_io_wait  = !tx_in_ready;

  // ==========================================================
  // Read data path
  // ==========================================================
  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = 16'h0000;
    unique case (index)
      `HSAP_PAD_CTRL:    rd_mux[7:0] = pad_ctrl;
      `HSAP_IRQ_CTRL:    rd_mux[7:0] = {6'h00, irq_ctrl};
      `HSAP_RX_PREFETCH,
      `HSAP_RX_PEEK,
      `HSAP_RX_STREAM:   rd_mux = wide ? rx_buf
                                  : {8'h00, rx_buf[7:0]};
      `HSAP_RX_PTR_HI:   rd_mux[7:0] = rx_ptr[15:8];
      `HSAP_RX_PTR_LO:   rd_mux[7:0] = rx_ptr[7:0];
      `HSAP_TX_PTR_HI:   rd_mux[7:0] = tx_ptr[15:8];
      `HSAP_TX_PTR_LO:   rd_mux[7:0] = tx_ptr[7:0];
      `HSAP_TX_LEN_HI:   rd_mux[7:0] = tx_len[15:8];
      `HSAP_TX_LEN_LO:   rd_mux[7:0] = tx_len[7:0];
      `HSAP_EVENTS:      rd_mux[7:0] = {narrow, 1'b0, flags};
      `HSAP_IRQ_ENABLE:  rd_mux[7:0] = irq_enable;
      default:           rd_mux = 16'h0000;
    endcase
  end

  // Drive only inside a selected data read
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_data    <= 16'h0000;
      o_data_oe <= 1'b0;
    end
    else
    begin
      o_data    <= rd_mux;
      o_data_oe <= !ior_f && !pin_s2.cs_n && pin_s2.cmd;
    end
  end

endmodule : hsap_top
`default_nettype wire

// ### sim/hsap_chk.sv
// Port-level assertions for the host access port
// Assumes it is bound onto hsap_top and sees only its ports
`default_nettype none
module hsap_chk
  import hsap_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_reset_n,
  input wire logic        i_tx_ready,
  input wire logic        o_tx_valid,
  input wire hsap_txw_t   o_tx_word,
  input wire logic        o_io_wait,
  input wire logic        o_irq,
  input wire logic        o_irq_oe,
  input wire logic        o_sys_clk_stop,
  input wire logic        o_phy_power_down,
  input wire logic        o_rx_prefetch,
  input wire logic [15:0] o_rx_addr,
  input wire logic [1:0]  o_drive_strength
);
  // ==========================================================
  // Clocking and sequences
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);
  // A stalled head word must neither move nor vanish
  sequence s_stall;
    o_tx_valid && !i_tx_ready;
  endsequence
  sequence s_held;
    o_tx_valid && $stable(o_tx_word);
  endsequence
  // ==========================================================
  // Assertions
  chk_tx_hold: assert property (s_stall |=> s_held)
    else $error("tx head word changed while stalled");
  chk_wait_full: assert property (o_io_wait |-> o_tx_valid)
    else $error("io wait raised with empty buffer");
  chk_pulse_once: assert property (o_rx_prefetch |=> !o_rx_prefetch)
    else $error("prefetch pulse longer than one cycle");
  chk_prefetch_ptr: assert property
    (o_rx_prefetch |-> $stable(o_rx_addr))
    else $error("read pointer moved on prefetch read");
  chk_irq_oe_init: assert property ($rose(i_reset_n) |=> o_irq_oe)
    else $error("irq driver not enabled after reset");
  chk_drive_reset: assert property
    ($rose(i_reset_n) |-> o_drive_strength == 2'h0 && !o_sys_clk_stop)
    else $error("pad or clock stop not at reset value");
  chk_oc_quiet: assert property (!o_irq_oe |-> !o_irq)
    else $error("irq level driven while driver off");
  chk_clk_phy: assert property (o_sys_clk_stop == o_phy_power_down)
    else $error("phy power down differs from clock stop");
endmodule : hsap_chk

bind hsap_top hsap_chk hsap_chk_inst (
  .i_ref_clk        (i_ref_clk),
  .i_reset_n        (i_reset_n),
  .i_tx_ready       (i_tx_ready),
  .o_tx_valid       (o_tx_valid),
  .o_tx_word        (o_tx_word),
  .o_io_wait        (o_io_wait),
  .o_irq            (o_irq),
  .o_irq_oe         (o_irq_oe),
  .o_sys_clk_stop   (o_sys_clk_stop),
  .o_phy_power_down (o_phy_power_down),
  .o_rx_prefetch    (o_rx_prefetch),
  .o_rx_addr        (o_rx_addr),
  .o_drive_strength (o_drive_strength)
);
`default_nettype wire

// ### sim/hsap_sram_model.sv
// Far-side model: RX SRAM read port and TX SRAM write sink
// Assumes the top's SRAM ports on the same clock
`default_nettype none
module hsap_sram_model
  import hsap_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_rx_addr,
  output logic      [15:0] o_rx_data,
  input  wire logic        i_tx_valid,
  input  wire hsap_txw_t   i_tx_word,
  output logic             o_tx_ready,
  input  wire logic        i_stall
);
  hsap_txw_t   seen [0:7];
  logic [3:0]  n_seen = 4'h0;
  // ==========================================================
  // RX SRAM: one-cycle latency, data derived from the address
  always_ff @(posedge i_ref_clk)
    o_rx_data <= i_rx_addr ^ 16'hA5C3;
  // TX sink: stalls on request so the buffer must hold its words
  assign o_tx_ready = !i_stall;
  always_ff @(posedge i_ref_clk)
    if (i_tx_valid && o_tx_ready)
    begin
      seen[n_seen[2:0]] <= i_tx_word;
      n_seen            <= n_seen + 4'h1;
    end
endmodule : hsap_sram_model
`default_nettype wire

// ### sim/hsap_top_bench.sv
// Self-checking bench for the host access port
// Assumes the SRAM model as far side, a 16-bit strap, then an 8-bit one
`default_nettype none
module hsap_top_bench
  import hsap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n = 1'b1, cmd = 1'b0, ior_n = 1'b1, iow_n = 1'b1;
  logic        stall = 1'b0;
  logic [15:0] din = 16'h0000;
  logic [5:0]  evt = 6'h00;
  logic        strap = 1'b0;
  int          pre_cnt = 0;
  logic [15:0] dout, rx_addr, rx_data, tx_len;
  logic        oe, io_wait, irq, irq_oe, clk_stop, pdn, hys, pre;
  logic        tx_valid, tx_ready;
  logic [1:0]  drv;
  hsap_txw_t   tx_word;
  int          num_errors = 0;
  int          check_count = 0;
  // ==========================================================
  // Clock, design and far side
  always #25 clk = ~clk;
  hsap_top hsap_top_inst (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_cmd(cmd),
    .i_ior_n(ior_n), .i_iow_n(iow_n), .i_data(din), .o_data(dout),
    .o_data_oe(oe), .o_io_wait(io_wait), .i_bus_8bit(strap),
    .o_irq(irq), .o_irq_oe(irq_oe), .i_event(evt),
    .o_sys_clk_stop(clk_stop), .o_phy_power_down(pdn),
    .o_drive_strength(drv), .o_hysteresis_en(hys),
    .o_rx_addr(rx_addr), .i_rx_data(rx_data), .o_rx_prefetch(pre),
    .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_tx_word(tx_word),
    .o_tx_length(tx_len));
  hsap_sram_model hsap_sram_model_inst (
    .i_ref_clk(clk), .i_rx_addr(rx_addr), .o_rx_data(rx_data),
    .i_tx_valid(tx_valid), .i_tx_word(tx_word), .o_tx_ready(tx_ready),
    .i_stall(stall));
  // Prefetch pulses counted mid-cycle, where the pulse has settled
  always @(negedge clk)
    if (pre === 1'b1)
      pre_cnt++;
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [32:0] e,
                     input logic [32:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One strobe; long hold because pins pass a sync and a filter
  task automatic bus(input logic c, input logic w, input logic [15:0] d,
                     output logic [15:0] q);
    @(negedge clk);
    cs_n = 1'b0;
    cmd = c;
    din = d;
    ior_n = w;
    iow_n = !w;
    repeat (8) @(negedge clk);
    q = dout;
    if (!w)
      chk("data_oe", 33'h1, {32'h0, oe});
    ior_n = 1'b1;
    iow_n = 1'b1;
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic [15:0] q;
    bus(1'b0, 1'b1, {8'h00, a}, q);
    bus(1'b1, 1'b1, v, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    bus(1'b0, 1'b1, {8'h00, a}, q);
    bus(1'b1, 1'b0, 16'h0000, q);
  endtask : rd
  task automatic final_report;
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // ==========================================================
  // Scenarios
  task automatic t_pad;
    logic [15:0] q;
    logic [7:0]  v;
    rd(8'h38, q);
    chk("pad_reset", 33'h01, {25'h0, q[7:0]});
    for (int d = 0; d < 4; d++)
    begin
      v = {1'b0, 2'(d), 5'h0B};
      wr(8'h38, {8'h00, v});
      rd(8'h38, q);
      chk("pad", {25'h0, v}, {25'h0, q[7:0]});
      chk("drive", 33'(d), {31'h0, drv});
    end
    chk("hysteresis", 33'h1, {32'h0, hys});
    rd(8'h20, q);
    chk("unmapped", 33'h0, {25'h0, q[7:0]});
  endtask : t_pad
  task automatic t_clock;
    logic [15:0] q;
    wr(8'h50, 16'h0001);
    chk("clk_stop", 33'h1, {32'h0, clk_stop});
    chk("phy_down", 33'h1, {32'h0, pdn});
    bus(1'b0, 1'b1, 16'h0051, q);
    chk("clk_resume", 33'h0, {32'h0, clk_stop});
  endtask : t_clock
  task automatic t_irq;
    logic [15:0] q;
    evt = 6'h21;
    @(negedge clk);
    evt = 6'h00;
    wr(8'hFF, 16'h0001);
    chk("irq_high", 33'h1, {32'h0, irq});
    rd(8'hFE, q);
    chk("status", 33'h21, {25'h0, q[7:0]});
    wr(8'hFE, 16'h0020);
    wr(8'h39, 16'h0001);
    chk("irq_low", 33'h0, {32'h0, irq});
    wr(8'h39, 16'h0003);
    chk("oc_on", 33'h1, {32'h0, irq_oe});
    wr(8'hFE, 16'h0000);
    rd(8'hFE, q);
    chk("zero_write", 33'h01, {25'h0, q[7:0]});
    wr(8'hFE, 16'h0001);
    chk("oc_off", 33'h0, {32'h0, irq_oe});
    wr(8'h39, 16'h0000);
    chk("direct_oe", 33'h1, {32'h0, irq_oe});
    chk("irq_idle", 33'h0, {32'h0, irq});
  endtask : t_irq
  task automatic t_rx;
    logic [15:0] q;
    wr(8'hF4, 16'h0012);
    wr(8'hF5, 16'h0034);
    chk("rx_ptr", 33'h1234, {17'h0, rx_addr});
    rd(8'hF4, q);
    chk("rx_ptr_hi", 33'h12, {25'h0, q[7:0]});
    rd(8'hF1, q);
    chk("peek", {17'h0, 16'h1234 ^ 16'hA5C3}, {17'h0, q});
    chk("peek_ptr", 33'h1234, {17'h0, rx_addr});
    rd(8'hF0, q);
    chk("prefetch", {17'h0, 16'h1234 ^ 16'hA5C3}, {17'h0, q});
    chk("prefetch_ptr", 33'h1234, {17'h0, rx_addr});
    chk("prefetch_pulse", 33'h1, 33'(pre_cnt));
    rd(8'hF2, q);
    chk("stream", {17'h0, 16'h1234 ^ 16'hA5C3}, {17'h0, q});
    chk("stream_ptr", 33'h1236, {17'h0, rx_addr});
    wr(8'hFF, 16'h0080);
    chk("wrap_hi", 33'h0C, {25'h0, rx_addr[15:8]});
    wr(8'hF4, 16'h003F);
    wr(8'hF5, 16'h00FE);
    rd(8'hF2, q);
    chk("rx_wrap", 33'h0C00, {17'h0, rx_addr});
  endtask : t_rx
  task automatic t_tx;
    logic [15:0] q;
    wr(8'hFA, 16'h0000);
    wr(8'hFB, 16'h0010);
    stall = 1'b1;
    wr(8'hF8, 16'hA5A5);
    wr(8'hF8, 16'h5A5A);
    chk("io_wait", 33'h1, {32'h0, io_wait});
    chk("head", {16'h0010, 16'hA5A5, 1'b1}, tx_word);
    rd(8'hFB, q);
    chk("tx_ptr", 33'h14, {25'h0, q[7:0]});
    stall = 1'b0;
    repeat (4) @(negedge clk);
    chk("sent", 33'h2, {29'h0, hsap_sram_model_inst.n_seen});
    chk("second", {16'h0012, 16'h5A5A, 1'b1},
        hsap_sram_model_inst.seen[1]);
    wr(8'hF6, 16'h1234);
    repeat (4) @(negedge clk);
    chk("fixed", {16'h0014, 16'h1234, 1'b1},
        hsap_sram_model_inst.seen[2]);
    rd(8'hFB, q);
    chk("fixed_ptr", 33'h14, {25'h0, q[7:0]});
    wr(8'hFC, 16'h0005);
    wr(8'hFD, 16'h00EA);
    chk("length", 33'h05EA, {17'h0, tx_len});
    rd(8'hFC, q);
    chk("length_hi", 33'h05, {25'h0, q[7:0]});
  endtask : t_tx
  // Second reset with the 8-bit strap: width flag and single steps
  task automatic t_narrow;
    logic [15:0] q;
    strap = 1'b1;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("oe_reset", 33'h1, {32'h0, irq_oe});
    rd(8'hFE, q);
    chk("width_8bit", 33'h80, {25'h0, q[7:0]});
    wr(8'hF4, 16'h0020);
    wr(8'hF5, 16'h0010);
    rd(8'hF2, q);
    chk("rx_narrow", {25'h0, 8'h10 ^ 8'hC3}, {17'h0, q});
    chk("rx_step1", 33'h2011, {17'h0, rx_addr});
    wr(8'hF8, 16'hAB77);
    repeat (4) @(negedge clk);
    chk("tx_narrow", {16'h0000, 16'h0077, 1'b0},
        hsap_sram_model_inst.seen[3]);
    rd(8'hFB, q);
    chk("tx_step1", 33'h01, {25'h0, q[7:0]});
  endtask : t_narrow
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_pad();
    t_clock();
    t_irq();
    t_rx();
    t_tx();
    t_narrow();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule : hsap_top_bench
`default_nettype wire
